/* shared/e1t2m_pkg.sv */
package e1t2m_pkg;

    // ==========================================================
    // Frame layout
    localparam int NUM_TRIB = 3;
    localparam logic [7:0] POS_FIRST = 8'h01;
    // 168 bits in each set
    localparam logic [7:0] SET_BITS = 8'ha8;
    localparam logic [7:0] ALIGN_LEN = 8'h09;
    // Alignment word 111010 000, sent from the most significant bit down
    localparam logic [8:0] ALIGN_WORD = 9'h1d0;
    localparam logic [7:0] POS_ALARM = 8'h01;
    localparam logic [7:0] POS_PARITY = 8'h02;
    localparam logic [7:0] POS_RESERVED = 8'h03;
    localparam logic RESERVED_VALUE = 1'h1;
    localparam logic [7:0] CTRL_LEN = 8'h03;
    localparam logic [7:0] STUFF_FIRST = 8'h04;
    localparam logic [7:0] STUFF_LAST = 8'h06;
    // Value sent in place of a missing tributary bit or an unused stuff bit
    localparam logic FILL_BIT = 1'h1;

    // ==========================================================
    // Rate and buffering
    localparam int CLK_RATE_KHZ = 50000;
    localparam int T2_RATE_KBPS = 6312;
    // Least clock cycles between two bit requests at the nominal T2 rate
    localparam int T2_BIT_CYCLES = CLK_RATE_KHZ / T2_RATE_KBPS;
    localparam int FIFO_WIDTH = 1;
    localparam int FIFO_DEPTH = 8;
    localparam int LEVEL_W = $clog2(FIFO_DEPTH + 1);
    // Fill level at or above which the stuff position carries data
    localparam logic [LEVEL_W-1:0] JUST_LEVEL = 4'h4;

    // ==========================================================
    // Set sequencer
    typedef enum logic [4:0] {
        SET1 = 5'h01,
        SET2 = 5'h02,
        SET3 = 5'h04,
        SET4 = 5'h08,
        SET5 = 5'h10
    } e1t2m_set_type;

endpackage

/* shared/e1t2m_stream_if.sv */
`timescale 1ns/10ps
interface e1t2m_stream_if #(
    parameter int WIDTH = 1
);
    logic [WIDTH-1:0] data;
    logic valid;
    logic ready;

    modport src (
        output data,
        output valid,
        input ready
    );

    modport snk (
        input data,
        input valid,
        output ready
    );
endinterface

/* hdl/e1t2m_fifo.sv */
`timescale 1ns/10ps
module e1t2m_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    e1t2m_stream_if.snk in_side,
    e1t2m_stream_if.src out_side,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int AW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH + 1);
    localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [LW-1:0] cnt_q, cnt_d;
    logic push, pop;

    // ==========================================================
    // Handshake
    assign in_side.ready = (cnt_q != LW'(DEPTH));
    assign out_side.valid = (cnt_q != '0);
    assign out_side.data = mem_q[rd_q];
    assign level = cnt_q;
    assign push = in_side.valid && in_side.ready;
    assign pop = out_side.valid && out_side.ready;

    // ==========================================================
    // Storage
    always_comb begin
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (push) begin
            mem_d[wr_q] = in_side.data;
            wr_d = (wr_q == LAST_IDX) ? '0 : wr_q + 1'b1;
        end
        if (pop) begin
            rd_d = (rd_q == LAST_IDX) ? '0 : rd_q + 1'b1;
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            mem_q <= mem_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end
endmodule

/* hdl/e1t2m_mux.sv */
// Notes on behaviour
// - A frame is five 168-bit sets, sent set one to five, repeating.
// - Set one opens with the nine-bit alignment word 111010000.
// - Set two opens with alarm bit, parity bit, then a reserved one.
// - Parity bit is one when previous frame's tributary ones count is odd.
// - Parity counts only tributary bits, never overhead or control bits.
// - Tributaries interleave 1,2,3; tributary 1 follows the alignment word.
// - First three bits of sets three to five carry control bits per tributary.
// - Majority-zero control bits mean the stuff position carries tributary data.
// - Bit one of set one is the first bit of every frame sent.
// - All positions up to bit 168 other than overhead, control and stuff bits carry interleaved tributary bits.
// - The output is one bit per t2_bit_req, so its rate is whatever the next stage requests, not fixed at 6.312 Mbit/s.
`timescale 1ns/10ps
module e1t2m_mux (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [2:0] trib_bit,
    input wire logic [2:0] trib_valid,
    output logic [2:0] trib_ready,
    input wire logic remote_alarm,
    input wire logic t2_bit_req,
    output logic t2_data,
    output logic t2_valid,
    output logic t2_frame_start,
    output logic [2:0] trib_underflow
);
    localparam int NT = e1t2m_pkg::NUM_TRIB;
    localparam int LW = e1t2m_pkg::LEVEL_W;

    // ==========================================================
    // Tributary buffers
    logic [2:0] fifo_valid;
    logic [2:0] fifo_data;
    logic [2:0] fifo_pop;
    logic [LW-1:0] fifo_level [NT];

    genvar g;
    generate
        for (g = 0; g < NT; g++) begin : g_trib
            e1t2m_stream_if #(.WIDTH(e1t2m_pkg::FIFO_WIDTH)) in_if ();
            e1t2m_stream_if #(.WIDTH(e1t2m_pkg::FIFO_WIDTH)) out_if ();

            assign in_if.data = trib_bit[g];
            assign in_if.valid = trib_valid[g];
            assign trib_ready[g] = in_if.ready;
            assign fifo_valid[g] = out_if.valid;
            assign fifo_data[g] = out_if.data;
            assign out_if.ready = fifo_pop[g];

            e1t2m_fifo #(
                .WIDTH(e1t2m_pkg::FIFO_WIDTH),
                .DEPTH(e1t2m_pkg::FIFO_DEPTH)
            ) u_fifo (
                .ref_clk(ref_clk),
                .rst(rst),
                .in_side(in_if),
                .out_side(out_if),
                .level(fifo_level[g])
            );
        end
    endgenerate

    // ==========================================================
    // Frame state
    e1t2m_pkg::e1t2m_set_type set_q, set_d;
    logic [7:0] pos_q, pos_d;
    logic [1:0] rot_q, rot_d;
    logic odd_run_q, odd_run_d;
    logic odd_prev_q, odd_prev_d;
    logic [2:0] use_data_q, use_data_d;
    logic t2_data_q, t2_data_d;
    logic t2_valid_q, t2_valid_d;
    logic frame_start_q, frame_start_d;
    logic [2:0] underflow_q, underflow_d;

    // Combinational working values for the bit being placed
    logic out_bit;
    logic take_trib;
    logic take_stuff;
    logic [1:0] stuff_idx;
    logic [1:0] ctrl_idx;
    logic [3:0] align_idx;
    logic counted;

    // ==========================================================
    // Bit placement
    always_comb begin
        set_d = set_q;
        pos_d = pos_q;
        rot_d = rot_q;
        odd_run_d = odd_run_q;
        odd_prev_d = odd_prev_q;
        use_data_d = use_data_q;
        t2_data_d = t2_data_q;
        t2_valid_d = 1'b0;
        frame_start_d = 1'b0;
        underflow_d = 3'h0;
        fifo_pop = 3'h0;
        out_bit = e1t2m_pkg::FILL_BIT;
        take_trib = 1'b0;
        take_stuff = 1'b0;
        counted = 1'b0;
        stuff_idx = 2'(pos_q - e1t2m_pkg::STUFF_FIRST);
        ctrl_idx = 2'(pos_q - e1t2m_pkg::POS_FIRST);
        align_idx = 4'(e1t2m_pkg::ALIGN_LEN - pos_q);

        // The next stage paces the stream; one bit per request
        if (t2_bit_req) begin
            case (set_q)
                e1t2m_pkg::SET1: begin
                    if (pos_q <= e1t2m_pkg::ALIGN_LEN) begin
                        out_bit = e1t2m_pkg::ALIGN_WORD[align_idx];
                    end else begin
                        take_trib = 1'b1;
                    end
                end
                e1t2m_pkg::SET2: begin
                    if (pos_q == e1t2m_pkg::POS_ALARM) begin
                        out_bit = remote_alarm;
                    end else if (pos_q == e1t2m_pkg::POS_PARITY) begin
                        out_bit = odd_prev_q;
                    end else if (pos_q == e1t2m_pkg::POS_RESERVED) begin
                        out_bit = e1t2m_pkg::RESERVED_VALUE;
                    end else begin
                        take_trib = 1'b1;
                    end
                end
                e1t2m_pkg::SET3, e1t2m_pkg::SET4: begin
                    if (pos_q <= e1t2m_pkg::CTRL_LEN) begin
                        out_bit = ~use_data_q[ctrl_idx];
                    end else begin
                        take_trib = 1'b1;
                    end
                end
                e1t2m_pkg::SET5: begin
                    if (pos_q <= e1t2m_pkg::CTRL_LEN) begin
                        out_bit = ~use_data_q[ctrl_idx];
                    end else if (pos_q <= e1t2m_pkg::STUFF_LAST) begin
                        // Unused stuff position sends fill, not data
                        take_stuff = use_data_q[stuff_idx];
                    end else begin
                        take_trib = 1'b1;
                    end
                end
                default: begin
                    out_bit = e1t2m_pkg::FILL_BIT;
                end
            endcase

            if (take_trib || take_stuff) begin
                // Stuff bits belong to a fixed tributary and leave the rotation alone
                if (take_trib) begin
                    rot_d = (rot_q == 2'(NT - 1)) ? 2'h0 : rot_q + 2'h1;
                end else begin
                    rot_d = rot_q;
                end
                if (take_trib) begin
                    stuff_idx = rot_q;
                end
                counted = 1'b1;
                if (fifo_valid[stuff_idx]) begin
                    out_bit = fifo_data[stuff_idx];
                    fifo_pop[stuff_idx] = 1'b1;
                end else begin
                    // An empty buffer still fills its slot so the frame keeps its shape
                    out_bit = e1t2m_pkg::FILL_BIT;
                    underflow_d[stuff_idx] = 1'b1;
                end
            end

            t2_data_d = out_bit;
            t2_valid_d = 1'b1;
            frame_start_d = (set_q == e1t2m_pkg::SET1) && (pos_q == e1t2m_pkg::POS_FIRST);
            if (counted) begin
                odd_run_d = odd_run_q ^ out_bit;
            end

            // Justification is fixed at the end of set two so all three copies agree
            if ((set_q == e1t2m_pkg::SET2) && (pos_q == e1t2m_pkg::SET_BITS)) begin
                for (int i = 0; i < NT; i++) begin
                    use_data_d[i] = (fifo_level[i] >= e1t2m_pkg::JUST_LEVEL);
                end
            end

            if (pos_q == e1t2m_pkg::SET_BITS) begin
                pos_d = e1t2m_pkg::POS_FIRST;
                case (set_q)
                    e1t2m_pkg::SET1: set_d = e1t2m_pkg::SET2;
                    e1t2m_pkg::SET2: set_d = e1t2m_pkg::SET3;
                    e1t2m_pkg::SET3: set_d = e1t2m_pkg::SET4;
                    e1t2m_pkg::SET4: set_d = e1t2m_pkg::SET5;
                    e1t2m_pkg::SET5: begin
                        set_d = e1t2m_pkg::SET1;
                        rot_d = 2'h0;
                        odd_prev_d = counted ? (odd_run_q ^ out_bit) : odd_run_q;
                        odd_run_d = 1'b0;
                    end
                    default: set_d = e1t2m_pkg::SET1;
                endcase
            end else begin
                pos_d = pos_q + 8'h01;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            set_q <= e1t2m_pkg::SET1;
            pos_q <= e1t2m_pkg::POS_FIRST;
            rot_q <= 2'h0;
            odd_run_q <= 1'b0;
            odd_prev_q <= 1'b0;
            use_data_q <= 3'h0;
            t2_data_q <= 1'b0;
            t2_valid_q <= 1'b0;
            frame_start_q <= 1'b0;
            underflow_q <= 3'h0;
        end else begin
            set_q <= set_d;
            pos_q <= pos_d;
            rot_q <= rot_d;
            odd_run_q <= odd_run_d;
            odd_prev_q <= odd_prev_d;
            use_data_q <= use_data_d;
            t2_data_q <= t2_data_d;
            t2_valid_q <= t2_valid_d;
            frame_start_q <= frame_start_d;
            underflow_q <= underflow_d;
        end
    end

    // ==========================================================
    // Outputs
    assign t2_data = t2_data_q;
    assign t2_valid = t2_valid_q;
    assign t2_frame_start = frame_start_q;
    assign trib_underflow = underflow_q;
endmodule

/* testbench/e1t2m_mux_monitor.sv */
`timescale 1ns/10ps
module e1t2m_mux_monitor (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [2:0] trib_bit,
    input wire logic [2:0] trib_valid,
    input wire logic [2:0] trib_ready,
    input wire logic remote_alarm,
    input wire logic t2_bit_req,
    input wire logic t2_data,
    input wire logic t2_valid,
    input wire logic t2_frame_start,
    input wire logic [2:0] trib_underflow
);
    // ==========================================================
    // Bits already delivered in the current frame
    logic [9:0] cnt_q;
    logic [9:0] cnt_d;
    logic seen_q;
    logic seen_d;
    always_comb begin
        cnt_d = cnt_q;
        seen_d = seen_q;
        if (t2_valid && t2_frame_start) begin
            cnt_d = 10'h001;
            seen_d = 1'h1;
        end else if (t2_valid) begin
            cnt_d = cnt_q + 10'h001;
        end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 10'h000;
            seen_q <= 1'h0;
        end else begin
            cnt_q <= cnt_d;
            seen_q <= seen_d;
        end
    end
    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_request;
        t2_bit_req;
    endsequence
    sequence s_answer;
        t2_valid;
    endsequence
    a_valid_follows_req: assert property (s_request |=> s_answer)
        else $error("requested bit not delivered");
    a_no_spurious_valid: assert property (!t2_bit_req |=> !t2_valid)
        else $error("bit delivered without request");
    a_start_is_one: assert property (t2_frame_start |-> t2_valid && t2_data)
        else $error("frame start not on a delivered one");
    a_frame_length: assert property (t2_valid && seen_q |->
        t2_frame_start == (cnt_q == 10'h348))
        else $error("frame length wrong");
    a_align_word: assert property (t2_valid && seen_q && !t2_frame_start
        && cnt_q < 10'h009 |-> t2_data == e1t2m_pkg::ALIGN_WORD[4'h8 - cnt_q[3:0]])
        else $error("alignment word wrong");
    a_alarm_bit: assert property (t2_valid && cnt_q == 10'h0a8
        |-> t2_data == $past(remote_alarm))
        else $error("alarm bit wrong");
    a_reserved_one: assert property (t2_valid && cnt_q == 10'h0aa |-> t2_data)
        else $error("reserved bit not one");
    a_fill_is_one: assert property (trib_underflow != 3'h0 |-> t2_valid && t2_data)
        else $error("underflow fill not a delivered one");
endmodule
bind e1t2m_mux e1t2m_mux_monitor mon (.ref_clk(ref_clk), .rst(rst), .trib_bit(trib_bit),
    .trib_valid(trib_valid), .trib_ready(trib_ready), .remote_alarm(remote_alarm),
    .t2_bit_req(t2_bit_req), .t2_data(t2_data), .t2_valid(t2_valid),
    .t2_frame_start(t2_frame_start), .trib_underflow(trib_underflow));

/* testbench/e1t2m_t2_stage.sv */
`timescale 1ns/10ps
module e1t2m_t2_stage (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [3:0] gap,
    output logic t2_bit_req
);
    // ==========================================================
    // Request pacing: one bit, then gap idle cycles
    logic [3:0] wait_q;
    logic [3:0] wait_d;
    logic req_d;
    always_comb begin
        req_d = run && (wait_q == 4'h0);
        wait_d = (wait_q == 4'h0) ? 4'h0 : wait_q - 4'h1;
        if (req_d) begin
            wait_d = gap;
        end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wait_q <= 4'h0;
            t2_bit_req <= 1'h0;
        end else begin
            wait_q <= wait_d;
            t2_bit_req <= req_d;
        end
    end
endmodule

/* testbench/e1_to_t2_frame_mux_test.sv */
`timescale 1ns/10ps
module e1_to_t2_frame_mux_test;
    logic ref_clk = 1'h0;
    logic rst = 1'h1;
    logic [2:0] trib_bit = 3'h0;
    logic [2:0] trib_valid = 3'h0;
    logic [2:0] trib_ready;
    logic remote_alarm = 1'h0;
    logic t2_bit_req;
    logic t2_data;
    logic t2_valid;
    logic t2_frame_start;
    logic [2:0] trib_underflow;
    logic run = 1'h0;
    logic [3:0] gap = 4'h0;
    int n_fail = 0;
    int checks = 0;
    int src_cnt = 0;
    logic q[0:2][$];
    always #10 ref_clk = ~ref_clk;
    e1t2m_mux DUT (.ref_clk(ref_clk), .rst(rst), .trib_bit(trib_bit),
        .trib_valid(trib_valid), .trib_ready(trib_ready), .remote_alarm(remote_alarm),
        .t2_bit_req(t2_bit_req), .t2_data(t2_data), .t2_valid(t2_valid),
        .t2_frame_start(t2_frame_start), .trib_underflow(trib_underflow));
    e1t2m_t2_stage far_end (.ref_clk(ref_clk), .rst(rst), .run(run), .gap(gap),
        .t2_bit_req(t2_bit_req));
    // ==========================================================
    // Tributary sources; the queues mirror what each FIFO holds
    always @(posedge ref_clk) begin
        for (int j = 0; j < 3; j++) begin
            if (!rst && trib_valid[j] && trib_ready[j]) begin
                q[j].push_back(trib_bit[j]);
            end
        end
        src_cnt <= src_cnt + 1;
        trib_bit <= {src_cnt[3] ^ src_cnt[0], src_cnt[2], src_cnt[1] ^ src_cnt[4]};
    end
    task automatic close_out();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic cmp(input logic [4:0] got, input logic [4:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic do_reset();
        @(posedge ref_clk);
        rst <= 1'h1;
        run <= 1'h0;
        repeat (5) @(posedge ref_clk);
        for (int j = 0; j < 3; j++) begin
            q[j].delete();
        end
        rst <= 1'h0;
        // Let the FIFOs fill before the far end starts asking
        repeat (12) @(posedge ref_clk);
        run <= 1'h1;
    endtask
    // Walks every delivered bit against the expected frame layout
    task automatic run_frames(input int nfr, input logic [2:0] use_d);
        int s;
        int b;
        int w;
        int rot;
        logic e;
        logic odd;
        logic acc;
        logic [2:0] u;
        logic [4:0] got_v;
        logic [4:0] exp_v;
        rot = 0;
        odd = 1'h0;
        acc = 1'h0;
        for (int k = 0; k < nfr * 840; k++) begin
            w = 0;
            do begin
                @(posedge ref_clk);
                #1;
                w++;
            end while (t2_valid !== 1'h1 && w < 50);
            if (w >= 50) begin
                n_fail++;
                close_out();
            end
            s = (k % 840) / 168 + 1;
            b = k % 168 + 1;
            u = 3'h0;
            if (k % 840 == 0) begin
                odd = acc;
                acc = 1'h0;
                rot = 0;
            end
            if (s == 1 && b <= 9) begin
                e = e1t2m_pkg::ALIGN_WORD[9 - b];
            end else if (s == 2 && b <= 3) begin
                e = (b == 1) ? remote_alarm : ((b == 2) ? odd : 1'h1);
            end else if (s >= 3 && b <= 3) begin
                e = ~use_d[b - 1];
            end else if (s == 5 && b <= 6) begin
                e = use_d[b - 4] ? q[b - 4].pop_front() : 1'h1;
                acc ^= e & use_d[b - 4];
            end else begin
                if (q[rot].size() > 0) begin
                    e = q[rot].pop_front();
                end else begin
                    e = 1'h1;
                    u[rot] = 1'h1;
                end
                acc ^= e;
                rot = (rot + 1) % 3;
            end
            got_v = {trib_underflow, t2_frame_start, t2_data};
            exp_v = {u, k % 840 == 0, e};
            cmp(got_v, exp_v);
        end
        run <= 1'h0;
    endtask
    // ==========================================================
    // Scenarios
    task automatic scen_back_to_back();
        trib_valid <= 3'h7;
        remote_alarm <= 1'h1;
        gap <= 4'h0;
        do_reset();
        run_frames(2, 3'h7);
    endtask
    task automatic scen_starved();
        trib_valid <= 3'h3;
        remote_alarm <= 1'h0;
        gap <= 4'(e1t2m_pkg::T2_BIT_CYCLES - 1);
        do_reset();
        run_frames(2, 3'h3);
    endtask
    initial begin
        scen_back_to_back();
        scen_starved();
        close_out();
    end
endmodule
